// [rtl/cxw_pkg.sv]
// Constants, register map and carrier types for the CAN transceiver control block
package cxw_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned WAKE_FILT_MIN_NS = 750;
  localparam int unsigned WAKE_FILT_CYC = (WAKE_FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CLAMP_DET_MIN_MS = 4;
  localparam int unsigned CLAMP_DET_CYC = (CLAMP_DET_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TX_DOM_MIN_MS = 4;
  localparam int unsigned TX_DOM_CYC = (TX_DOM_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_COMMAND_REG_FIRST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_OPERATING_STATUS_FIRST = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_COMM_DIAGNOSIS_REG = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_MODE_CONFIG = 8'h0c;

  // Field positions
  localparam int unsigned CMD_WAKE_CLEAR_BIT = 0;
  localparam int unsigned ST_WAKE_FLAG_BIT = 0;
  localparam int unsigned ST_WAKE_EN_BIT = 1;
  localparam int unsigned ST_SLEEP_BIT = 2;
  localparam int unsigned ST_SUPPLY_BIT = 3;
  localparam int unsigned DG_BUS_CLAMP_BIT = 0;
  localparam int unsigned DG_TX_TIMEOUT_BIT = 1;
  localparam int unsigned DG_OVERTEMP_BIT = 2;
  localparam int unsigned CFG_RX_ONLY_BIT = 0;

  // Reset values
  localparam logic CFG_RX_ONLY_RST = 1'h0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic xcvr_overtemp_flag;
    logic tx_timeout_flag;
    logic bus_clamp_flag;
  } cxw_diag_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } cxw_bus_req_t;

  typedef enum logic [1:0] {
    WK_OFF,
    WK_WAIT_REC,
    WK_WAIT_DOM,
    WK_FILTER
  } cxw_wk_state_t;
endpackage

// [rtl/cxw_transceiver_ctrl.sv]
// Digital control of a high-speed CAN transceiver: modes, remote wake, diagnosis flags
//
// Functional notes
// R01 - Receive-only mode: driver disabled, transmit input ignored, nothing reaches bus.
// R02 - Receive-only mode: receiver stays active and reports bus state.
// R03 - Failure detection keeps running in receive-only mode as in normal mode.
// R04 - Unpowered: no driving, receiver network disconnected, bus lines high impedance.
// R05 - Wake detection enabled when wake strap is tied to standby supply.
// R06 - Wake strap tied to ground disables wake detection completely.
// R07 - In sleep, recessive then dominant longer than filter time sets wake flag.
// R08 - Writing 1 to wake-clear bit of first command register clears wake flag.
// R09 - Wake flag is readable in first operating-status register.
// R10 - After clear, only a fresh recessive-to-dominant transition wakes again.
// R11 - Bus held dominant by a fault sets the bus-clamp flag.
// R12 - Transmit input stuck dominant too long sets transmit time-out flag.
// R13 - Overtemperature condition sets the transceiver overtemperature flag.
// R14 - Failure detection changes only diagnosis flags, never configuration or mode.
// R15 - Normal mode: driver forwards transmit input, receiver reports bus state.
// R16 - Wake filter time lies between 0.75 and 5 microseconds.
// R17 - Bus-clamp flag rises only after 4 to 7 ms of dominant bus.
// R18 - Time-out flag rises only after 4 to 7 ms of dominant transmit input.
// R19 - Diagnosis flags stay set until software clears them.
// R20 - Mode comes from a configuration setting that steers the driver enable.
`timescale 1ns/1ps
module cxw_transceiver_ctrl
  import cxw_pkg::*;
#(
  parameter int unsigned CLAMP_CYC = CLAMP_DET_CYC,
  parameter int unsigned TX_TO_CYC = TX_DOM_CYC
)
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic i_tx_data_in,
  output logic o_rx_data_out,
  input wire logic i_bus_level,
  output logic o_bus_dominant,
  output logic o_bus_drv_oe_n,
  output logic o_rx_network_en,
  input wire logic i_wake_enable_strap,
  input wire logic i_supply_ok,
  input wire logic i_overtemp,
  input wire logic i_ecu_sleep,
  output logic o_bus_wake_flag
);
  localparam int unsigned CL_W = $clog2(CLAMP_CYC + 1);
  localparam int unsigned TX_W = $clog2(TX_TO_CYC + 1);
  localparam int unsigned WK_W = $clog2(WAKE_FILT_CYC + 1);
  localparam logic [CL_W-1:0] CL_LAST = CL_W'(CLAMP_CYC - 1);
  localparam logic [CL_W-1:0] CL_SAT = CL_W'(CLAMP_CYC);
  localparam logic [TX_W-1:0] TX_LAST = TX_W'(TX_TO_CYC - 1);
  localparam logic [TX_W-1:0] TX_SAT = TX_W'(TX_TO_CYC);
  localparam logic [WK_W-1:0] WK_LAST = WK_W'(WAKE_FILT_CYC - 1);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic tx_dom_s;
  logic bus_dom_s;
  logic strap_s;
  logic supply_s;
  logic ot_s;

  // Pins are asynchronous; only sync_b is read by logic
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      sync_a <= 5'h0b;
      sync_b <= 5'h0b;
    end
    else
    begin
      sync_a <= {i_overtemp, i_supply_ok, i_wake_enable_strap, i_bus_level, i_tx_data_in};
      sync_b <= sync_a;
    end
  end

  // Low level on the transmit input and on the bus means dominant
  assign tx_dom_s = ~sync_b[0];
  assign bus_dom_s = ~sync_b[1];
  assign strap_s = sync_b[2];
  assign supply_s = sync_b[3];
  assign ot_s = sync_b[4];

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  cxw_bus_req_t req;
  cxw_diag_t diag;
  cxw_diag_t diag_set;
  cxw_diag_t diag_clr;
  logic cfg_rx_only;
  logic wake_flag;
  logic wake_set;
  logic wake_clr;
  logic cfg_wr;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign cfg_wr = req.wr && (req.addr == ADDR_MODE_CONFIG);
  assign wake_clr = req.wr && (req.addr == ADDR_COMMAND_REG_FIRST) && req.wdata[CMD_WAKE_CLEAR_BIT]; // R08
  assign diag_clr = (req.wr && (req.addr == ADDR_COMM_DIAGNOSIS_REG))
    ? cxw_diag_t'({req.wdata[DG_OVERTEMP_BIT], req.wdata[DG_TX_TIMEOUT_BIT], req.wdata[DG_BUS_CLAMP_BIT]})
    : cxw_diag_t'(3'h0);

  // Only software writes move the mode; detection logic has no path here
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      cfg_rx_only <= CFG_RX_ONLY_RST;
    else if (cfg_wr)
      cfg_rx_only <= req.wdata[CFG_RX_ONLY_BIT]; // R20 R14
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_rdata <= RDATA_ZERO;
    else if (req.rd)
    begin
      o_rdata <= RDATA_ZERO;
      unique case (req.addr)
        ADDR_OPERATING_STATUS_FIRST:
        begin
          o_rdata[ST_WAKE_FLAG_BIT] <= wake_flag; // R09
          o_rdata[ST_WAKE_EN_BIT] <= strap_s;
          o_rdata[ST_SLEEP_BIT] <= i_ecu_sleep;
          o_rdata[ST_SUPPLY_BIT] <= supply_s;
        end
        ADDR_COMM_DIAGNOSIS_REG:
        begin
          o_rdata[DG_BUS_CLAMP_BIT] <= diag.bus_clamp_flag;
          o_rdata[DG_TX_TIMEOUT_BIT] <= diag.tx_timeout_flag;
          o_rdata[DG_OVERTEMP_BIT] <= diag.xcvr_overtemp_flag;
        end
        ADDR_MODE_CONFIG:
          o_rdata[CFG_RX_ONLY_BIT] <= cfg_rx_only;
        default:
          o_rdata <= RDATA_ZERO;
      endcase
    end
    else
      o_rdata <= RDATA_ZERO;
  end

  // ----------------------------------------------------------------
  // Driver and receiver path
  // ----------------------------------------------------------------
  logic drv_active;

  assign drv_active = supply_s && !cfg_rx_only; // R01 R04 R20

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_bus_drv_oe_n <= 1'h1;
      o_bus_dominant <= 1'h0;
      o_rx_network_en <= 1'h0;
      o_rx_data_out <= 1'h1;
    end
    else
    begin
      o_bus_drv_oe_n <= !drv_active; // R01 R04 R15
      o_bus_dominant <= drv_active && tx_dom_s; // R01 R15
      o_rx_network_en <= supply_s; // R04
      o_rx_data_out <= supply_s ? !bus_dom_s : 1'h1; // R02 R15
    end
  end

  // ----------------------------------------------------------------
  // Diagnosis
  // ----------------------------------------------------------------
  logic [CL_W-1:0] clamp_cnt;
  logic [TX_W-1:0] txd_cnt;
  logic detect_on;

  // Same detection in both modes; sleep or no supply stops clamp and time-out detection, overtemperature only stops without supply
  assign detect_on = supply_s && !i_ecu_sleep; // R03

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !detect_on || !bus_dom_s)
      clamp_cnt <= '0;
    else if (clamp_cnt != CL_SAT)
      clamp_cnt <= clamp_cnt + 1'b1; // R11 R17
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || !detect_on || !tx_dom_s)
      txd_cnt <= '0;
    else if (txd_cnt != TX_SAT)
      txd_cnt <= txd_cnt + 1'b1; // R12 R18
  end

  assign diag_set.bus_clamp_flag = detect_on && bus_dom_s && (clamp_cnt == CL_LAST); // R11 R17
  assign diag_set.tx_timeout_flag = detect_on && tx_dom_s && (txd_cnt == TX_LAST); // R12 R18
  assign diag_set.xcvr_overtemp_flag = supply_s && ot_s; // R13

  // Sticky; a set in the clearing cycle wins so no event is lost
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      diag <= cxw_diag_t'(3'h0);
    else
      diag <= diag_set | (diag & ~diag_clr); // R19 R14
  end

  // ----------------------------------------------------------------
  // Remote wake
  // ----------------------------------------------------------------
  cxw_wk_state_t wk_state;
  cxw_wk_state_t next_wk_state;
  logic [WK_W-1:0] wk_cnt;

  // Arming only from recessive means a clamped bus cannot wake again
  always_comb
  begin
    next_wk_state = wk_state;
    unique case (wk_state)
      WK_OFF:
        next_wk_state = WK_WAIT_REC;
      WK_WAIT_REC:
        if (!bus_dom_s)
          next_wk_state = WK_WAIT_DOM; // R10
      WK_WAIT_DOM:
        if (bus_dom_s)
          next_wk_state = WK_FILTER; // R07
      WK_FILTER:
        if (!bus_dom_s)
          next_wk_state = WK_WAIT_DOM;
        else if (wk_cnt == WK_LAST)
          next_wk_state = WK_WAIT_REC; // R10
    endcase
    if (!strap_s || !i_ecu_sleep)
      next_wk_state = WK_OFF; // R05 R06
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      wk_state <= WK_OFF;
    else
      wk_state <= next_wk_state;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst || wk_state != WK_FILTER || !bus_dom_s)
      wk_cnt <= '0;
    else
      wk_cnt <= wk_cnt + 1'b1; // R16
  end

  assign wake_set = strap_s && i_ecu_sleep && (wk_state == WK_FILTER) && bus_dom_s && (wk_cnt == WK_LAST); // R07 R16

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      wake_flag <= 1'h0;
    else if (wake_set)
      wake_flag <= 1'h1; // R07
    else if (wake_clr)
      wake_flag <= 1'h0; // R08
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_bus_wake_flag <= 1'h0;
    else
      o_bus_wake_flag <= wake_set || (wake_flag && !wake_clr);
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_dom_filtered;
    (wk_state == WK_FILTER) && bus_dom_s && (wk_cnt == WK_LAST) && strap_s && i_ecu_sleep;
  endsequence

  sequence s_wake_cleared;
    wake_clr && !wake_set;
  endsequence

  a_rxonly_no_drive: assert property (cfg_rx_only |=> o_bus_drv_oe_n && !o_bus_dominant) // R01
    else $error("driver active in receive-only mode");
  a_rx_reports_bus: assert property (supply_s |=> o_rx_data_out == !$past(bus_dom_s)) // R02
    else $error("receive output does not follow bus");
  a_rxonly_detect: assert property (cfg_rx_only && detect_on && tx_dom_s && txd_cnt == TX_LAST
    |=> diag.tx_timeout_flag) // R03
    else $error("time-out detection stopped in receive-only mode");
  a_unpowered_quiet: assert property (!supply_s |=> o_bus_drv_oe_n && !o_rx_network_en) // R04
    else $error("bus loaded while unpowered");
  a_strap_enables: assert property (strap_s && i_ecu_sleep && wk_state == WK_OFF |=> wk_state == WK_WAIT_REC) // R05
    else $error("wake detection not armed with strap high");
  a_strap_blocks: assert property (!strap_s && !wake_flag |=> !wake_flag) // R06
    else $error("wake raised with strap low");
  a_wake_filter_set: assert property (s_dom_filtered |=> wake_flag && o_bus_wake_flag) // R07
    else $error("filtered dominant did not wake");
  a_wake_min_filter: assert property ($rose(wake_flag) // R16
    |-> $past(wk_state) == WK_FILTER && $past(wk_cnt) == WK_LAST)
    else $error("wake shorter than filter time");
  a_wake_clear: assert property (s_wake_cleared |=> !wake_flag && !o_bus_wake_flag) // R08
    else $error("wake clear ignored");
  a_wake_status: assert property (req.rd && req.addr == ADDR_OPERATING_STATUS_FIRST
    |=> o_rdata[ST_WAKE_FLAG_BIT] == $past(wake_flag)) // R09
    else $error("status does not show wake flag");
  a_no_rewake: assert property (s_dom_filtered ##1 bus_dom_s [*8] |-> wk_state == WK_WAIT_REC) // R10
    else $error("held dominant bus re-armed wake");
  a_clamp_time: assert property ($rose(diag.bus_clamp_flag) |-> $past(clamp_cnt) == CL_LAST) // R11 R17
    else $error("clamp flag before detection time");
  a_txto_time: assert property ($rose(diag.tx_timeout_flag) // R12 R18
    |-> $past(txd_cnt) == TX_LAST && $past(tx_dom_s))
    else $error("time-out flag before detection time");
  a_overtemp_flag: assert property (supply_s && ot_s |=> diag.xcvr_overtemp_flag) // R13
    else $error("overtemperature not flagged");
  a_cfg_untouched: assert property ((diag_set != cxw_diag_t'(3'h0)) && !cfg_wr |=> $stable(cfg_rx_only)) // R14
    else $error("failure changed the mode");
  // Reset drops on a clock edge; the attempt at that edge sees outputs still in reset
  a_normal_forward: assert property (!i_rst && supply_s && !cfg_rx_only
    |=> !o_bus_drv_oe_n && o_bus_dominant == $past(tx_dom_s)) // R15
    else $error("normal mode not forwarding transmit data");
  a_flag_sticky: assert property (diag.bus_clamp_flag && !diag_clr.bus_clamp_flag |=> diag.bus_clamp_flag) // R19
    else $error("clamp flag lost without clear");
  a_clamp_set: assert property (detect_on && bus_dom_s && clamp_cnt == CL_LAST // R11
    |=> diag.bus_clamp_flag)
    else $error("clamp flag not raised after detection time");
  a_wake_sleep_only: assert property (!i_ecu_sleep |=> !$rose(wake_flag)) // R07
    else $error("wake raised outside sleep");
  a_rdata_idle: assert property (!req.rd |=> o_rdata == RDATA_ZERO) // R09
    else $error("read data outside read cycle");
endmodule // cxw_transceiver_ctrl

// [verif/cxw_can_ctrl_model.sv]
// Behavioural model of the CAN protocol controller on the transmit pin
`timescale 1ns/1ps
module cxw_can_ctrl_model
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_tx_bit,
  output logic o_tx_data_in = 1'h1
);
  // ----------------------------------------------------------------
  // Transmit
  // ----------------------------------------------------------------
  // Recessive in reset so the transceiver never sees a false dominant
  always @(posedge i_core_clk)
  begin
    if (i_rst)
      o_tx_data_in <= 1'h1;
    else
      o_tx_data_in <= i_tx_bit;
  end
endmodule // cxw_can_ctrl_model

// [verif/testbench.sv]
// Self-checking testbench for the CAN transceiver control block
`timescale 1ns/1ps
module testbench;
  import cxw_pkg::*;
  // Short detection count keeps the fault scenarios fast
  localparam int unsigned DET_CYC = 20;
  logic i_core_clk = 1'h0;
  logic i_rst = 1'h1;
  logic [ADDR_W-1:0] i_addr = 8'h00;
  logic [DATA_W-1:0] i_wdata = 32'h0;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic [DATA_W-1:0] o_rdata;
  logic i_tx_data_in;
  logic o_rx_data_out;
  logic i_bus_level = 1'h1;
  logic o_bus_dominant;
  logic o_bus_drv_oe_n;
  logic o_rx_network_en;
  logic i_wake_enable_strap = 1'h1;
  logic i_supply_ok = 1'h1;
  logic i_overtemp = 1'h0;
  logic i_ecu_sleep = 1'h0;
  logic o_bus_wake_flag;
  logic tx_bit = 1'h1;
  logic ext_bus = 1'h1;
  int num_errors = 0;
  int checked = 0;

  // ----------------------------------------------------------------
  // Clock, bus and instances
  // ----------------------------------------------------------------
  always #25 i_core_clk = ~i_core_clk;

  // Wired bus: our driver dominant wins, else the external party sets it
  always @(posedge i_core_clk)
    i_bus_level <= (!o_bus_drv_oe_n && o_bus_dominant) ? 1'h0 : ext_bus;

  cxw_transceiver_ctrl #(.CLAMP_CYC(DET_CYC), .TX_TO_CYC(DET_CYC)) i_cxw_transceiver_ctrl (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_data_in(i_tx_data_in),
    .o_rx_data_out(o_rx_data_out), .i_bus_level(i_bus_level), .o_bus_dominant(o_bus_dominant),
    .o_bus_drv_oe_n(o_bus_drv_oe_n), .o_rx_network_en(o_rx_network_en),
    .i_wake_enable_strap(i_wake_enable_strap), .i_supply_ok(i_supply_ok),
    .i_overtemp(i_overtemp), .i_ecu_sleep(i_ecu_sleep), .o_bus_wake_flag(o_bus_wake_flag));

  cxw_can_ctrl_model i_cxw_can_ctrl_model (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_tx_bit(tx_bit), .o_tx_data_in(i_tx_data_in));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'h0;
    #1;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string msg);
    @(posedge i_core_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'h0;
    #1;
    chk_word(o_rdata, exp, msg);
  endtask

  task automatic set_pins(input logic tx, input logic bus, input logic slp, input logic strap, input logic sup,
                          input logic ot);
    @(posedge i_core_clk);
    tx_bit <= tx;
    ext_bus <= bus;
    i_ecu_sleep <= slp;
    i_wake_enable_strap <= strap;
    i_supply_ok <= sup;
    i_overtemp <= ot;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    // Synchronisers still hold their reset values for two edges after release
    cyc(2);
    rd_chk(ADDR_OPERATING_STATUS_FIRST, 32'ha, "status");
    rd_chk(ADDR_MODE_CONFIG, 32'h0, "config");
    rd_chk(ADDR_COMM_DIAGNOSIS_REG, 32'h0, "diag");
    rd_chk(8'h10, 32'h0, "unmapped");
  endtask

  task automatic t_normal();
    set_pins(1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
    cyc(10);
    chk_pin(o_bus_dominant, 1'h1, "drive dom");
    chk_pin(o_bus_drv_oe_n, 1'h0, "oe normal");
    chk_pin(o_rx_data_out, 1'h0, "rx dom");
    set_pins(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
    cyc(10);
    chk_pin(o_bus_dominant, 1'h0, "drive rec");
    chk_pin(o_rx_data_out, 1'h1, "rx rec");
    rd_chk(ADDR_COMM_DIAGNOSIS_REG, 32'h0, "short dom");
  endtask

  task automatic t_rx_only();
    wr_reg(ADDR_MODE_CONFIG, 32'h1);
    set_pins(1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
    cyc(30);
    chk_pin(o_bus_drv_oe_n, 1'h1, "oe rx only");
    chk_pin(o_bus_dominant, 1'h0, "dom rx only");
    chk_pin(o_rx_data_out, 1'h1, "bus quiet");
    rd_chk(ADDR_COMM_DIAGNOSIS_REG, 32'h2, "tx timeout");
    rd_chk(ADDR_MODE_CONFIG, 32'h1, "mode kept");
    set_pins(1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
    cyc(8);
    chk_pin(o_rx_data_out, 1'h0, "rx in rx only");
    set_pins(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
    cyc(8);
    wr_reg(ADDR_COMM_DIAGNOSIS_REG, 32'h2);
    wr_reg(ADDR_MODE_CONFIG, 32'h0);
    rd_chk(ADDR_COMM_DIAGNOSIS_REG, 32'h0, "diag clear");
  endtask

  task automatic t_clamp();
    set_pins(1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
    cyc(30);
    set_pins(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
    cyc(6);
    rd_chk(ADDR_COMM_DIAGNOSIS_REG, 32'h1, "clamp");
    chk_pin(o_bus_wake_flag, 1'h0, "awake no wake");
    rd_chk(ADDR_COMM_DIAGNOSIS_REG, 32'h1, "clamp sticky");
    wr_reg(ADDR_COMM_DIAGNOSIS_REG, 32'h1);
    rd_chk(ADDR_COMM_DIAGNOSIS_REG, 32'h0, "clamp clear");
  endtask

  task automatic t_overtemp();
    set_pins(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1);
    cyc(4);
    set_pins(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
    cyc(4);
    rd_chk(ADDR_COMM_DIAGNOSIS_REG, 32'h4, "overtemp");
    rd_chk(ADDR_MODE_CONFIG, 32'h0, "mode kept");
    chk_pin(o_bus_drv_oe_n, 1'h0, "driver kept");
    wr_reg(ADDR_COMM_DIAGNOSIS_REG, 32'h4);
    rd_chk(ADDR_COMM_DIAGNOSIS_REG, 32'h0, "ot clear");
  endtask

  task automatic t_wake();
    set_pins(1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0);
    cyc(6);
    set_pins(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0);
    cyc(10);
    chk_pin(o_bus_wake_flag, 1'h0, "short dom");
    set_pins(1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0);
    cyc(6);
    set_pins(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0);
    cyc(25);
    chk_pin(o_bus_wake_flag, 1'h1, "wake");
    rd_chk(ADDR_OPERATING_STATUS_FIRST, 32'hf, "status wake");
    wr_reg(ADDR_COMMAND_REG_FIRST, 32'h1);
    chk_pin(o_bus_wake_flag, 1'h0, "wake clear");
    cyc(30);
    chk_pin(o_bus_wake_flag, 1'h0, "held dom");
    rd_chk(ADDR_OPERATING_STATUS_FIRST, 32'he, "status held");
    set_pins(1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0);
    cyc(6);
    set_pins(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0);
    cyc(25);
    chk_pin(o_bus_wake_flag, 1'h1, "rewake");
    wr_reg(ADDR_COMMAND_REG_FIRST, 32'h1);
    set_pins(1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0);
    cyc(6);
    set_pins(1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
    cyc(25);
    chk_pin(o_bus_wake_flag, 1'h0, "strap off");
    rd_chk(ADDR_OPERATING_STATUS_FIRST, 32'hc, "status off");
    set_pins(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
    cyc(6);
  endtask

  task automatic t_unpowered();
    set_pins(1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
    cyc(8);
    chk_pin(o_rx_network_en, 1'h0, "network off");
    chk_pin(o_bus_drv_oe_n, 1'h1, "oe off");
    chk_pin(o_bus_dominant, 1'h0, "dom off");
    chk_pin(o_rx_data_out, 1'h1, "rx off");
    set_pins(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0);
    cyc(8);
    chk_pin(o_rx_network_en, 1'h1, "network on");
  endtask

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge i_core_clk);
    i_rst <= 1'h0;
    t_reset();
    t_normal();
    t_rx_only();
    t_clamp();
    t_overtemp();
    t_wake();
    t_unpowered();
    stop_test();
  end

  // Scenarios need well under 1000 cycles; 5000 leaves room without hiding a hang
  initial
  begin
    #(5000 * 50);
    num_errors++;
    stop_test();
  end
endmodule // testbench
